// ==== clock_source_select.sv ====
/*
  per-channel source clock picker: turns a clock select code, the power
  mode and the divider tap select into one count-enable pulse.
  assumes the prescaler pulses and pin edge pulse are one cycle long and
  already in the ref_clk_in domain.
*/
`timescale 1ns/1ps
module clock_source_select #(
  parameter bit FAST_IN_LOW_POWER = 1'b0
) (
  input wire logic [2:0] clock_select_in,
  input wire logic low_power_in,
  input wire logic divider_tap_select_in,
  input wire logic warmup_mode_in,
  input wire logic fast_tick_in,
  input wire logic div2_tick_in,
  input wire logic div8_tick_in,
  input wire logic div32_tick_in,
  input wire logic div128_tick_in,
  input wire logic div2048_tick_in,
  input wire logic slow_tick_in,
  input wire logic slow_div8_tick_in,
  input wire logic pin_tick_in,
  output logic count_tick_out
);

  // ---------------------------------------------------------------
  // source decode
  // ---------------------------------------------------------------
  // low power keeps only the slow taps, the pin and warm-up fast clock
  always_comb begin
    count_tick_out = 1'b0;
    unique case (clock_select_in)
      timer_pair_pkg::CK_DIV2048: begin
        count_tick_out = (low_power_in || divider_tap_select_in) ? slow_div8_tick_in
                                                                 : div2048_tick_in;
      end
      timer_pair_pkg::CK_DIV128: count_tick_out = !low_power_in && div128_tick_in;
      timer_pair_pkg::CK_DIV32: count_tick_out = !low_power_in && div32_tick_in;
      timer_pair_pkg::CK_DIV8: count_tick_out = !low_power_in && div8_tick_in;
      timer_pair_pkg::CK_SLOW: count_tick_out = slow_tick_in;
      timer_pair_pkg::CK_DIV2: count_tick_out = !low_power_in && div2_tick_in;
      timer_pair_pkg::CK_FAST: begin
        count_tick_out = fast_tick_in &&
                         (!low_power_in || (FAST_IN_LOW_POWER && warmup_mode_in));
      end
      timer_pair_pkg::CK_PIN: count_tick_out = pin_tick_in;
    endcase
  end

endmodule // clock_source_select

// ==== compare_counter.sv ====
/*
  8-bit up-counter with period match: counts on enable, clears on stop
  and on match, flags the match for one cycle.
  assumes count_tick_in is a one-cycle enable on ref_clk_in.
*/
`timescale 1ns/1ps
module compare_counter #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic count_tick_in,
  input wire logic [WIDTH-1:0] match_in,
  input wire logic match_enable_in,
  output logic [WIDTH-1:0] count_out,
  output logic match_out,
  output logic overflow_out
);

  logic [WIDTH-1:0] count_d;
  logic hit;

  assign hit = match_enable_in && (count_d == match_in);

  // next count after a tick
  always_comb begin
    count_d = count_out + WIDTH'(1);
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // stop clears counter
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !run_in) begin
      count_out <= '0;
    end else if (count_tick_in) begin
      count_out <= hit ? '0 : count_d;
    end
  end

  // one-cycle match and wrap pulses
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      match_out <= 1'b0;
      overflow_out <= 1'b0;
    end else begin
      match_out <= run_in && count_tick_in && hit;
      overflow_out <= run_in && count_tick_in && (count_out == '1) && !hit;
    end
  end

endmodule // compare_counter

// ==== testbench.sv ====
/* self-checking bench for timer_pair_control.
   assumes the register map and clock codes of timer_pair_pkg. */
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [1:0] power_mode_in = 2'h0;
  logic divider_tap_select_in = 1'b0;
  logic slow_tick_in = 1'b0;
  logic timer_a_pin_in = 1'b0;
  logic timer_b_pin_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic timer_a_match_interrupt_out;
  logic timer_b_match_interrupt_out;
  logic timer_a_flipflop_out;
  logic [2:0] active_mode_out;
  int err_count = 0;
  int tests_run = 0;
  int seed = 32'hc537;
  int cyc = 0;
  // ------------------------------------------
  // clock code, divide, power mode, tap select
  // ------------------------------------------
  logic [2:0] ck [11] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4, 3'h7, 3'h4, 3'h0, 3'h0};
  int dv [11] = '{1, 2, 8, 32, 128, 128, 16, 10, 16, 128, 2048};
  logic [1:0] pw [11] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0};
  logic ts [11] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
  timer_pair_control #(.WIDTH(8)) i_dut (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .power_mode_in, .divider_tap_select_in, .slow_tick_in,
    .timer_a_pin_in, .timer_b_pin_in, .reg_rdata_out, .timer_a_match_interrupt_out,
    .timer_b_match_interrupt_out, .timer_a_flipflop_out, .timer_b_flipflop_out(),
    .cascade_out(), .active_mode_out, .reserved_mode_out());
  always #4 ref_clk_in = ~ref_clk_in;
  // slow tick every 16 cycles, pin a rises every 10, pin b is noise
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    slow_tick_in <= cyc % 16 == 0;
    timer_a_pin_in <= cyc % 10 < 5;
    timer_b_pin_in <= 1'($random(seed));
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one write cycle, then a gap so strobes never change twice at one edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_write_in <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_read_in <= 1'b0;
    #1 chk("read", {8'h00, reg_rdata_out}, {8'h00, exp});
  endtask
  // cycles until the next interrupt pulse of channel a or b
  task automatic wait_irq(input bit b, output int k);
    k = 0;
    do begin
      @(posedge ref_clk_in);
      #1 k++;
    end while ((b ? timer_b_match_interrupt_out : timer_a_match_interrupt_out) !== 1'b1
      && k < 9000);
    if (k >= 9000) begin
      err_count++;
      test_done();
    end
  endtask
  initial begin
    int g;
    int n;
    logic [7:0] d;
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd_chk(8'h1a, 8'h00);
    rd_chk(8'h1b, 8'h00);
    rd_chk(8'h22, 8'hff);
    rd_chk(8'h30, 8'h00);
    // random stopped settings read back
    repeat (8) begin
      d = 8'($random(seed));
      wr_reg(8'h1b, d & 8'hf7);
      rd_chk(8'h1b, d & 8'hf7);
      wr_reg(8'h21, d);
      rd_chk(8'h21, d);
    end
    // b back to a stopped 8-bit timer so a runs on its own bits
    wr_reg(8'h1b, 8'h00);
    // flip-flop start level follows bit 7 while stopped
    for (n = 0; n < 2; n++) begin
      wr_reg(8'h1a, {n[0], 7'h00});
      @(posedge ref_clk_in);
      #1 chk("ff a", {15'h0, timer_a_flipflop_out}, 16'(n));
    end
    // every source and power mode, stop write clears the count
    wr_reg(8'h20, 8'h04);
    foreach (ck[i]) begin
      @(posedge ref_clk_in);
      power_mode_in <= pw[i];
      divider_tap_select_in <= ts[i];
      wr_reg(8'h1a, {1'b0, ck[i], 4'h8});
      wait_irq(1'b0, g);
      wait_irq(1'b0, g);
      chk("gap a", 16'(g), 16'(4 * dv[i]));
      wr_reg(8'h1a, {1'b0, ck[i], 4'h0});
      rd_chk(8'h24, 8'h00);
    end
    // the divide-by-2 tap gives nothing in sleep
    @(posedge ref_clk_in);
    power_mode_in <= 2'h3;
    wr_reg(8'h1a, 8'h58);
    n = 0;
    repeat (200) begin
      @(posedge ref_clk_in);
      #1 n += 32'(timer_a_match_interrupt_out !== 1'b0);
    end
    chk("sleep irq", 16'(n), 16'h0);
    wr_reg(8'h1a, 8'h50);
    power_mode_in <= 2'h0;
    wr_reg(8'h22, 8'h05);
    wr_reg(8'h1b, 8'h68);
    wait_irq(1'b1, g);
    wait_irq(1'b1, g);
    chk("gap b", 16'(g), 16'h5);
    wr_reg(8'h1b, 8'h60);
    // cascade: clock from a, run from b, compare 0x0103
    wr_reg(8'h22, 8'h01);
    wr_reg(8'h20, 8'h03);
    wr_reg(8'h1a, 8'h63);
    wr_reg(8'h1b, 8'h0c);
    wait_irq(1'b1, g);
    wait_irq(1'b1, g);
    chk("gap 16", 16'(g), 16'h0103);
    chk("mode", {13'h0, active_mode_out}, 16'h4);
    wr_reg(8'h1b, 8'h04);
    rd_chk(8'h25, 8'h00);
    wr_reg(8'h1b, 8'h03);
    test_done();
  end
endmodule // testbench

// ==== timer_pair_checker.sv ====
/* assertions on the timer pair control ports.
   assumes one clock and the register map of timer_pair_pkg. */
`timescale 1ns/1ps
module timer_pair_checker #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic timer_a_match_interrupt_out,
  input wire logic timer_a_flipflop_out,
  input wire logic timer_b_flipflop_out,
  input wire logic cascade_out,
  input wire logic [2:0] active_mode_out,
  input wire logic reserved_mode_out
);
  // ---------------------------------
  // shadow of the two control bytes
  // ---------------------------------
  logic [7:0] ctl_a_q;
  logic [7:0] ctl_b_q;
  logic casc;
  logic stop_a;
  assign casc = ctl_b_q[2] && ctl_a_q[2:0] == 3'h3;
  assign stop_a = ctl_b_q[2] ? !ctl_b_q[3] : !ctl_a_q[3]; // b top mode bit hands run to b
  // copies bus writes so outputs can be tied to the bytes written
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ctl_a_q <= 8'h00;
      ctl_b_q <= 8'h00;
    end else if (reg_write_in) begin
      if (reg_addr_in == 8'h1a) ctl_a_q <= reg_wdata_in;
      if (reg_addr_in == 8'h1b) ctl_b_q <= reg_wdata_in;
    end
  end
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_ctl_a_read: assert property ($past(reg_read_in && reg_addr_in == 8'h1a)
    |-> reg_rdata_out == $past(ctl_a_q)) else $error("control a read wrong");
  a_ctl_b_read: assert property ($past(reg_read_in && reg_addr_in == 8'h1b)
    |-> reg_rdata_out == $past(ctl_b_q)) else $error("control b read wrong");
  a_unmapped_zero: assert property (
    $past(reg_read_in && !(reg_addr_in inside {8'h1a, 8'h1b, [8'h20:8'h25]}))
    |-> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_ff_b_init: assert property (!$past(ctl_b_q[3])
    |-> timer_b_flipflop_out == $past(ctl_b_q[7])) else $error("ff b wrong");
  a_ff_a_init: assert property (!$past(ctl_b_q[2]) && !$past(ctl_a_q[3])
    |-> timer_a_flipflop_out == $past(ctl_a_q[7])) else $error("ff a wrong");
  a_cascade_flag: assert property (cascade_out == $past(casc))
    else $error("cascade flag wrong");
  a_mode_16bit: assert property (cascade_out |-> active_mode_out == $past(ctl_b_q[2:0]))
    else $error("active mode wrong");
  a_reserved_flag: assert property (reserved_mode_out == $past(ctl_b_q[2:0] == 3'h3))
    else $error("reserved flag wrong");
  a_stop_clears: assert property (
    $past(reg_read_in && reg_addr_in == 8'h24) && $past(stop_a) && $past(stop_a, 2)
    |-> reg_rdata_out == 8'h00) else $error("stopped count not zero");
  a_cascade_quiet: assert property (cascade_out [*4] |-> !timer_a_match_interrupt_out)
    else $error("low half interrupt in cascade");
  // main scenarios
  c_irq_a: cover property (timer_a_match_interrupt_out);
  c_cascade: cover property (cascade_out);
  c_reserved: cover property (reserved_mode_out);
endmodule // timer_pair_checker
bind timer_pair_control timer_pair_checker #(.WIDTH(WIDTH)) i_chk (.ref_clk_in, .rst_n_in,
  .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
  .timer_a_match_interrupt_out, .timer_a_flipflop_out, .timer_b_flipflop_out,
  .cascade_out, .active_mode_out, .reserved_mode_out);

// ==== timer_pair_control.sv ====
/*
  control for a pair of cascadable 8-bit timer/counters: control and
  compare registers, prescaler, source selection, counters and the
  timer flip-flop initial state.
  assumes a plain register port on ref_clk_in, a slow-clock tick
  input from logic on the same clock, and two asynchronous count pins.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module timer_pair_control #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [1:0] power_mode_in,
  input wire logic divider_tap_select_in,
  input wire logic slow_tick_in,
  input wire logic timer_a_pin_in,
  input wire logic timer_b_pin_in,
  output logic [7:0] reg_rdata_out,
  output logic timer_a_match_interrupt_out,
  output logic timer_b_match_interrupt_out,
  output logic timer_a_flipflop_out,
  output logic timer_b_flipflop_out,
  output logic cascade_out,
  output logic [2:0] active_mode_out,
  output logic reserved_mode_out
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] timer_a_control_q;
  logic [7:0] timer_b_control_q;
  logic [WIDTH-1:0] timer_a_period_match_q;
  logic [WIDTH-1:0] timer_b_period_match_q;
  logic [WIDTH-1:0] timer_a_pulse_width_q;
  logic [WIDTH-1:0] timer_b_pulse_width_q;

  logic timer_a_flipflop_ctl;
  logic timer_b_flipflop_ctl;
  logic [2:0] timer_a_clock_select;
  logic [2:0] timer_b_clock_select;
  logic timer_a_run;
  logic timer_b_run;
  logic [2:0] timer_a_mode_select;
  logic [2:0] timer_b_mode_select;

  assign timer_a_flipflop_ctl = timer_a_control_q[timer_pair_pkg::FF_BIT];
  assign timer_b_flipflop_ctl = timer_b_control_q[timer_pair_pkg::FF_BIT];
  assign timer_a_clock_select = timer_a_control_q[timer_pair_pkg::CK_HI:timer_pair_pkg::CK_LO];
  assign timer_b_clock_select = timer_b_control_q[timer_pair_pkg::CK_HI:timer_pair_pkg::CK_LO];
  assign timer_a_run = timer_a_control_q[timer_pair_pkg::RUN_BIT];
  assign timer_b_run = timer_b_control_q[timer_pair_pkg::RUN_BIT];
  assign timer_a_mode_select =
    timer_a_control_q[timer_pair_pkg::MODE_HI:timer_pair_pkg::MODE_LO];
  assign timer_b_mode_select =
    timer_b_control_q[timer_pair_pkg::MODE_HI:timer_pair_pkg::MODE_LO];

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  logic cascade;
  logic low_power;
  logic effective_a_run;
  logic effective_b_run;
  logic warmup;

  // top bit of b mode means 16-bit operation
  assign cascade = timer_b_mode_select[2];
  assign low_power = (power_mode_in == 2'(timer_pair_pkg::PWR_LOW_SPEED)) ||
                     (power_mode_in == 2'(timer_pair_pkg::PWR_SLEEP));
  assign warmup = cascade && (timer_b_mode_select == timer_pair_pkg::MODE_WARMUP);
  // in 16-bit both halves follow b run
  assign effective_a_run = cascade ? timer_b_run : timer_a_run;
  assign effective_b_run = timer_b_run;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // control registers reset to zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      timer_a_control_q <= timer_pair_pkg::CONTROL_RESET;
    end else if (reg_write_in && reg_addr_in == timer_pair_pkg::TIMER_A_CONTROL_OFS) begin
      timer_a_control_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      timer_b_control_q <= timer_pair_pkg::CONTROL_RESET;
    end else if (reg_write_in && reg_addr_in == timer_pair_pkg::TIMER_B_CONTROL_OFS) begin
      timer_b_control_q <= reg_wdata_in;
    end
  end

  // compare registers; leave rewrite timing to software
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      timer_a_period_match_q <= WIDTH'(timer_pair_pkg::COMPARE_RESET);
      timer_b_period_match_q <= WIDTH'(timer_pair_pkg::COMPARE_RESET);
      timer_a_pulse_width_q <= WIDTH'(timer_pair_pkg::COMPARE_RESET);
      timer_b_pulse_width_q <= WIDTH'(timer_pair_pkg::COMPARE_RESET);
    end else if (reg_write_in) begin
      unique case (reg_addr_in)
        timer_pair_pkg::TIMER_A_PERIOD_OFS: timer_a_period_match_q <= WIDTH'(reg_wdata_in);
        timer_pair_pkg::TIMER_A_WIDTH_OFS: timer_a_pulse_width_q <= WIDTH'(reg_wdata_in);
        timer_pair_pkg::TIMER_B_PERIOD_OFS: timer_b_period_match_q <= WIDTH'(reg_wdata_in);
        timer_pair_pkg::TIMER_B_WIDTH_OFS: timer_b_pulse_width_q <= WIDTH'(reg_wdata_in);
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic [1:0] pin_last_q;
  logic [1:0] pin_tick;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
      pin_last_q <= 2'h0;
    end else begin
      pin_meta_q <= {timer_b_pin_in, timer_a_pin_in};
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  // count on rising pin edges
  assign pin_tick = pin_sync_q & ~pin_last_q;

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  logic [timer_pair_pkg::PRESCALE_BITS-1:0] prescale_q;
  logic [timer_pair_pkg::PRESCALE_BITS-1:0] prescale_d;
  logic [timer_pair_pkg::PRESCALE_BITS-1:0] tap_tick;
  logic [2:0] slow_div_q;
  logic slow_div8_tick;

  assign prescale_d = prescale_q + timer_pair_pkg::PRESCALE_BITS'(1);

  // free running; one tick per tap when its low bits roll over
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_d;
    end
  end

  genvar t;
  generate
    for (t = 0; t < timer_pair_pkg::PRESCALE_BITS; t++) begin : g_tap
      // tap t pulses once every 2**t cycles
      if (t == 0) begin : g_zero
        assign tap_tick[t] = 1'b1;
      end else begin : g_rest
        assign tap_tick[t] = &prescale_q[t-1:0];
      end
    end
  endgenerate

  // slow clock divided by eight
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      slow_div_q <= 3'h0;
    end else if (slow_tick_in) begin
      slow_div_q <= slow_div_q + 3'h1;
    end
  end

  assign slow_div8_tick = slow_tick_in && (slow_div_q == 3'h7);

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  logic a_tick;
  logic b_own_tick;
  logic b_tick;
  logic a_match;
  logic b_match;

  clock_source_select #(
    .FAST_IN_LOW_POWER(1'b1)
  ) u_select_a (
    .clock_select_in(timer_a_clock_select),
    .low_power_in(low_power),
    .divider_tap_select_in(divider_tap_select_in),
    .warmup_mode_in(warmup),
    .fast_tick_in(tap_tick[0]),
    .div2_tick_in(tap_tick[1]),
    .div8_tick_in(tap_tick[timer_pair_pkg::TAP_DIV8]),
    .div32_tick_in(tap_tick[timer_pair_pkg::TAP_DIV32]),
    .div128_tick_in(tap_tick[timer_pair_pkg::TAP_DIV128]),
    .div2048_tick_in(tap_tick[timer_pair_pkg::TAP_DIV2048]),
    .slow_tick_in(slow_tick_in),
    .slow_div8_tick_in(slow_div8_tick),
    .pin_tick_in(pin_tick[0]),
    .count_tick_out(a_tick)
  );

  // channel b has no low power fast clock
  clock_source_select #(
    .FAST_IN_LOW_POWER(1'b0)
  ) u_select_b (
    .clock_select_in(timer_b_clock_select),
    .low_power_in(low_power),
    .divider_tap_select_in(divider_tap_select_in),
    .warmup_mode_in(1'b0),
    .fast_tick_in(tap_tick[0]),
    .div2_tick_in(tap_tick[1]),
    .div8_tick_in(tap_tick[timer_pair_pkg::TAP_DIV8]),
    .div32_tick_in(tap_tick[timer_pair_pkg::TAP_DIV32]),
    .div128_tick_in(tap_tick[timer_pair_pkg::TAP_DIV128]),
    .div2048_tick_in(tap_tick[timer_pair_pkg::TAP_DIV2048]),
    .slow_tick_in(slow_tick_in),
    .slow_div8_tick_in(slow_div8_tick),
    .pin_tick_in(pin_tick[1]),
    .count_tick_out(b_own_tick)
  );


  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] a_count;
  logic [WIDTH-1:0] b_count;
  logic a_match_en;
  logic b_match_en;
  logic [WIDTH-1:0] a_period;
  logic [WIDTH-1:0] b_period;
  logic pair_match;
  logic [2*WIDTH-1:0] pair_count_d;

  // high half steps on the low half carry, in the same tick
  assign b_tick = cascade ? (a_tick && a_count == '1) : b_own_tick;
  // 16-bit match compares both halves at once, so single halves wrap freely
  assign a_match_en = !cascade;
  assign b_match_en = !cascade;
  assign a_period = timer_a_period_match_q;
  assign b_period = timer_b_period_match_q;

  compare_counter #(
    .WIDTH(WIDTH)
  ) u_count_a (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in && !pair_match),
    .run_in(effective_a_run),
    .count_tick_in(a_tick),
    .match_in(a_period),
    .match_enable_in(a_match_en),
    .count_out(a_count),
    .match_out(a_match),
    .overflow_out()
  );

  compare_counter #(
    .WIDTH(WIDTH)
  ) u_count_b (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in && !pair_match),
    .run_in(effective_b_run),
    .count_tick_in(b_tick),
    .match_in(b_period),
    .match_enable_in(b_match_en),
    .count_out(b_count),
    .match_out(b_match),
    .overflow_out()
  );

  // 16-bit match on the tick that reaches the period clears both halves at once,
  // so the pair never shows the period value, just like an 8-bit channel
  assign pair_count_d = {b_count, a_count} + (2*WIDTH)'(1);
  assign pair_match = cascade && timer_b_run && a_tick &&
                      (pair_count_d == {b_period, a_period});

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // match raises the channel interrupt
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      timer_a_match_interrupt_out <= 1'b0;
      timer_b_match_interrupt_out <= 1'b0;
    end else begin
      timer_a_match_interrupt_out <= !cascade && a_match;
      timer_b_match_interrupt_out <= cascade ? pair_match : b_match;
    end
  end

  // initial flip-flop state while stopped; b controls 16-bit
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      timer_a_flipflop_out <= 1'b0;
      timer_b_flipflop_out <= 1'b0;
    end else begin
      if (!effective_a_run) begin
        timer_a_flipflop_out <= cascade ? timer_b_flipflop_ctl : timer_a_flipflop_ctl;
      end
      if (!effective_b_run) begin
        timer_b_flipflop_out <= timer_b_flipflop_ctl;
      end
    end
  end

  // decoded operating mode for the waveform logic
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cascade_out <= 1'b0;
      active_mode_out <= timer_pair_pkg::MODE_TIMER8;
      reserved_mode_out <= 1'b0;
    end else begin
      cascade_out <= cascade && (timer_a_mode_select == timer_pair_pkg::MODE_CASCADE);
      // in 16-bit the b field names the mode
      active_mode_out <= cascade ? timer_b_mode_select : timer_a_mode_select;
      reserved_mode_out <= (timer_b_mode_select == timer_pair_pkg::MODE_CASCADE);
    end
  end

  // ---------------------------------------------------------------
  // register reads, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        timer_pair_pkg::TIMER_A_CONTROL_OFS: reg_rdata_out <= timer_a_control_q;
        timer_pair_pkg::TIMER_B_CONTROL_OFS: reg_rdata_out <= timer_b_control_q;
        timer_pair_pkg::TIMER_A_PERIOD_OFS: reg_rdata_out <= 8'(timer_a_period_match_q);
        timer_pair_pkg::TIMER_A_WIDTH_OFS: reg_rdata_out <= 8'(timer_a_pulse_width_q);
        timer_pair_pkg::TIMER_B_PERIOD_OFS: reg_rdata_out <= 8'(timer_b_period_match_q);
        timer_pair_pkg::TIMER_B_WIDTH_OFS: reg_rdata_out <= 8'(timer_b_pulse_width_q);
        timer_pair_pkg::COUNT_A_OFS: reg_rdata_out <= 8'(a_count);
        timer_pair_pkg::COUNT_B_OFS: reg_rdata_out <= 8'(b_count);
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule // timer_pair_control

// ==== timer_pair_pkg.sv ====
/*
  constants shared by the dual 8-bit timer control block: register offsets,
  control field positions, reset values, clock select and mode codes.
  assumes the including design runs on a single 125 MHz clock.
*/
package timer_pair_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [7:0] TIMER_A_CONTROL_OFS = 8'h1a;
  localparam logic [7:0] TIMER_B_CONTROL_OFS = 8'h1b;
  // compare registers have no printed address
  localparam logic [7:0] TIMER_A_PERIOD_OFS = 8'h20;
  localparam logic [7:0] TIMER_A_WIDTH_OFS = 8'h21;
  localparam logic [7:0] TIMER_B_PERIOD_OFS = 8'h22;
  localparam logic [7:0] TIMER_B_WIDTH_OFS = 8'h23;
  localparam logic [7:0] COUNT_A_OFS = 8'h24;
  localparam logic [7:0] COUNT_B_OFS = 8'h25;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int FF_BIT = 7;
  localparam int CK_HI = 6;
  localparam int CK_LO = 4;
  localparam int RUN_BIT = 3;
  localparam int MODE_HI = 2;
  localparam int MODE_LO = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'hff;

  // ---------------------------------------------------------------
  // clock select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CK_DIV2048 = 3'h0;
  localparam logic [2:0] CK_DIV128 = 3'h1;
  localparam logic [2:0] CK_DIV32 = 3'h2;
  localparam logic [2:0] CK_DIV8 = 3'h3;
  localparam logic [2:0] CK_SLOW = 3'h4;
  localparam logic [2:0] CK_DIV2 = 3'h5;
  localparam logic [2:0] CK_FAST = 3'h6;
  localparam logic [2:0] CK_PIN = 3'h7;

  // ---------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_TIMER8 = 3'h0;
  localparam logic [2:0] MODE_DIVOUT8 = 3'h1;
  localparam logic [2:0] MODE_PWM8 = 3'h2;
  localparam logic [2:0] MODE_CASCADE = 3'h3;
  localparam logic [2:0] MODE_TIMER16 = 3'h4;
  localparam logic [2:0] MODE_WARMUP = 3'h5;
  localparam logic [2:0] MODE_PWM16 = 3'h6;
  localparam logic [2:0] MODE_PULSEGEN = 3'h7;

  // divider taps, as powers of two of the fast clock; TAP_SLOW_DIV8 as a power of two of the slow clock
  localparam int TAP_DIV2048 = 11;
  localparam int TAP_DIV128 = 7;
  localparam int TAP_DIV32 = 5;
  localparam int TAP_DIV8 = 3;
  localparam int TAP_SLOW_DIV8 = 3;
  localparam int PRESCALE_BITS = 12;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_IDLE,
    PWR_LOW_SPEED,
    PWR_SLEEP
  } power_mode_t;

endpackage : timer_pair_pkg
